/* design/hbfm_top.sv */
// Fault manager of a six-channel half-bridge driver with an APB register slave.
// Assumes comparator inputs are raw levels; one clock, ref_clk at 100 MHz.
// Contract
// R1: A latched-off fault disables the channel and zeroes its enable and config bits.
// R2: The host clears the flag and rewrites the channel before the driver runs again.
// R3: A locked-out channel returns to its programmed state when the fault ends.
// R4: Fault flags and per-channel latched-off state are kept apart.
// R5: Over-current latches its flag and turns off both switches until the flag is cleared.
// R6: Thermal warning never latches, leaves outputs alone and clears itself.
// R7: Thermal shutdown latches and needs a reset frame plus a cool die to clear.
// R8: Supply under-voltage, or over-voltage with the option set, locks out all drivers unlatched.
// R9: Over-voltage lockout recovers by itself once the supply is back below threshold.
// R10: Latched faults clear on a reset frame, an enable-pin toggle or power-on reset.
// R11: Persistent under-load sets its flag and latches off only with shutdown control set.
// R12: Over-current latches off only after the shutdown delay, then raises its flag; the code sets latch-off and the flag on the same clock edge.
// R13: Thermal warning appears in bit 0 of the serial output word.
// R14: Comparator inputs pass through a two-stage synchroniser before use.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "hbfm_defs.svh"

module hbfm_top (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chip_enable,
  input wire logic frame_valid,
  input wire logic [15:0] frame_data,
  input wire hbfm_pkg::hbfm_sense_t sense,
  output hbfm_pkg::hbfm_drive_t drive,
  output logic [`HBFM_NCH-1:0] bridge_active,
  output logic [15:0] serial_status,
  output logic irq
);
  import hbfm_pkg::*;

  localparam int NCH = `HBFM_NCH;
  localparam int OC_DELAY_CYC = `HBFM_OC_DELAY_CYC;

  hbfm_sense_t sync1_ff;
  hbfm_sense_t sync2_ff;
  logic en_prev_ff;
  logic [NCH-1:0] bridge_channel_enable_ff;
  logic [NCH-1:0] bridge_channel_config_ff;
  logic underload_shutdown_control_ff;
  logic overvoltage_lockout_option_ff;
  logic [NCH-1:0] latched_off_ff;
  logic overcurrent_shutdown_flag_ff;
  logic tsd_flag_ff;
  logic underload_flag_ff;
  logic [NCH-1:0] tsd_chan_ff;
  logic [NCH-1:0][13:0] oc_cnt_ff;
  logic [`HBFM_IRQ_W-1:0] irq_stat_ff;
  logic [`HBFM_IRQ_W-1:0] irq_mask_ff;
  logic warn_seen_ff;
  logic [NCH-1:0] oc_fire;
  logic [NCH-1:0] ul_fire;
  logic [NCH-1:0] tsd_fire;
  logic thermal_warning_flag;
  logic supply_fail_flag;
  logic lockout;
  logic status_reset_request;
  logic apb_wr;
  logic apb_rd;
  logic [`HBFM_IRQ_W-1:0] irq_event;
  logic [NCH-1:0] nxt_active;
  logic [15:0] nxt_serial;
  logic [31:0] nxt_prdata;
  logic nxt_slverr;

  // Two-stage synchroniser on comparator inputs
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end
    else
    begin
      sync1_ff <= sense; // [R14]
      sync2_ff <= sync1_ff; // [R14]
    end
  end

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;

  // Reset frame, from the serial link or mirrored over APB, or enable-pin cycle
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      en_prev_ff <= 1'b0;
    else
      en_prev_ff <= chip_enable;
  end

  assign status_reset_request = (frame_valid && frame_data[`HBFM_FRAME_STATUS_RESET_BIT])
    || (apb_wr && paddr == `HBFM_ADDR_FRAME && pwdata[`HBFM_FRAME_STATUS_RESET_BIT])
    || (chip_enable && !en_prev_ff); // [R10]

  generate
    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
      // Over-current must persist for the shutdown delay
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          oc_cnt_ff[i] <= '0;
        else if (!sync2_ff.oc[i] || latched_off_ff[i])
          oc_cnt_ff[i] <= '0;
        else if (oc_cnt_ff[i] != 14'(OC_DELAY_CYC))
          oc_cnt_ff[i] <= oc_cnt_ff[i] + 14'h0001;
      end
      assign oc_fire[i] = sync2_ff.oc[i] && oc_cnt_ff[i] == 14'(OC_DELAY_CYC - 1); // [R12]
      assign ul_fire[i] = sync2_ff.underload[i] && bridge_channel_enable_ff[i];
      assign tsd_fire[i] = sync2_ff.tsd[i] && !tsd_chan_ff[i];

      // Per-channel latched-off state, separate from flags
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          latched_off_ff[i] <= 1'b0;
        else if (oc_fire[i] || tsd_fire[i] || (ul_fire[i] && underload_shutdown_control_ff)) // [R1] [R5] [R7] [R11]
          latched_off_ff[i] <= 1'b1; // [R4]
        else if (status_reset_request && !(tsd_chan_ff[i] && !sync2_ff.tsd_clear[i])) // [R10]
          latched_off_ff[i] <= 1'b0;
      end

      // Thermal shutdown memory per channel
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
          tsd_chan_ff[i] <= 1'b0;
        else if (sync2_ff.tsd[i])
          tsd_chan_ff[i] <= 1'b1; // [R7]
        else if (status_reset_request && sync2_ff.tsd_clear[i])
          tsd_chan_ff[i] <= 1'b0; // [R7]
      end

      // Channel control; latch-off forces zero, host must rewrite
      always_ff @(posedge ref_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          bridge_channel_enable_ff[i] <= 1'b0;
          bridge_channel_config_ff[i] <= 1'b0;
        end
        else if (oc_fire[i] || tsd_fire[i] || (ul_fire[i] && underload_shutdown_control_ff) || latched_off_ff[i])
        begin
          bridge_channel_enable_ff[i] <= 1'b0; // [R1] [R2]
          bridge_channel_config_ff[i] <= 1'b0; // [R1]
        end
        else if (apb_wr && paddr == `HBFM_ADDR_CHCFG)
        begin
          bridge_channel_enable_ff[i] <= pwdata[i];
          bridge_channel_config_ff[i] <= pwdata[8+i];
        end
      end

      // Lockout hides the drive but keeps stored config
      assign nxt_active[i] = bridge_channel_enable_ff[i] && !latched_off_ff[i] && !lockout; // [R3] [R8]
    end
  endgenerate

  assign thermal_warning_flag = |sync2_ff.warn; // [R6]
  assign supply_fail_flag = sync2_ff.supply_uv || sync2_ff.supply_ov; // [R8]
  assign lockout = sync2_ff.supply_uv || (sync2_ff.supply_ov && overvoltage_lockout_option_ff); // [R8] [R9]

  // Latched fault flags; a new event wins over the clear
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overcurrent_shutdown_flag_ff <= 1'b0;
      tsd_flag_ff <= 1'b0;
      underload_flag_ff <= 1'b0;
    end
    else
    begin
      if (|oc_fire)
        overcurrent_shutdown_flag_ff <= 1'b1; // [R5] [R12]
      else if (status_reset_request)
        overcurrent_shutdown_flag_ff <= 1'b0; // [R10]
      if (|sync2_ff.tsd)
        tsd_flag_ff <= 1'b1; // [R7]
      else if (status_reset_request && (sync2_ff.tsd_clear & tsd_chan_ff) == tsd_chan_ff)
        tsd_flag_ff <= 1'b0; // [R7]
      if (|ul_fire)
        underload_flag_ff <= 1'b1; // [R11]
      else if (status_reset_request)
        underload_flag_ff <= 1'b0; // [R10]
    end
  end

  // Control register, also updated by serial frames
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      underload_shutdown_control_ff <= 1'b0;
      overvoltage_lockout_option_ff <= 1'b0;
    end
    else if (frame_valid)
    begin
      underload_shutdown_control_ff <= frame_data[`HBFM_FRAME_UL_SHUTDOWN_BIT];
      overvoltage_lockout_option_ff <= frame_data[`HBFM_FRAME_OV_LOCK_BIT];
    end
    else if (apb_wr && paddr == `HBFM_ADDR_CTRL)
    begin
      underload_shutdown_control_ff <= pwdata[0];
      overvoltage_lockout_option_ff <= pwdata[1];
    end
  end

  // Interrupt status, write one to clear, set wins
  assign irq_event[`HBFM_IRQ_OVERCURRENT] = |oc_fire;
  assign irq_event[`HBFM_IRQ_TSD] = |tsd_fire;
  assign irq_event[`HBFM_IRQ_UNDERLOAD] = |ul_fire && !underload_flag_ff;
  assign irq_event[`HBFM_IRQ_WARN] = thermal_warning_flag && !warn_seen_ff;
  assign irq_event[`HBFM_IRQ_SUPPLY] = supply_fail_flag && !serial_status[`HBFM_SO_SUPPLY_BIT];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat_ff <= '0;
      irq_mask_ff <= '0;
      warn_seen_ff <= 1'b0;
    end
    else
    begin
      warn_seen_ff <= thermal_warning_flag;
      irq_stat_ff <= irq_event | (irq_stat_ff
        & ~((apb_wr && paddr == `HBFM_ADDR_IRQ_STAT) ? pwdata[`HBFM_IRQ_W-1:0] : '0));
      if (apb_wr && paddr == `HBFM_ADDR_IRQ_MASK)
        irq_mask_ff <= pwdata[`HBFM_IRQ_W-1:0];
    end
  end

  always_comb
  begin
    nxt_serial = '0;
    nxt_serial[`HBFM_SO_WARN_BIT] = thermal_warning_flag; // [R13]
    nxt_serial[`HBFM_SO_UNDERLOAD_BIT] = underload_flag_ff;
    nxt_serial[`HBFM_SO_SUPPLY_BIT] = supply_fail_flag;
    nxt_serial[`HBFM_SO_OVERCURRENT_BIT] = overcurrent_shutdown_flag_ff || tsd_flag_ff;
  end

  always_comb
  begin
    nxt_prdata = '0;
    nxt_slverr = 1'b0;
    case (paddr)
      `HBFM_ADDR_CTRL: nxt_prdata = {30'h0, overvoltage_lockout_option_ff, underload_shutdown_control_ff};
      `HBFM_ADDR_CHCFG: nxt_prdata = {18'h0, bridge_channel_config_ff, 2'h0, bridge_channel_enable_ff};
      `HBFM_ADDR_FRAME: nxt_prdata = '0;
      `HBFM_ADDR_STATUS: nxt_prdata = {tsd_flag_ff, 15'h0, serial_status};
      `HBFM_ADDR_IRQ_STAT: nxt_prdata = {27'h0, irq_stat_ff};
      `HBFM_ADDR_IRQ_MASK: nxt_prdata = {27'h0, irq_mask_ff};
      `HBFM_ADDR_LATCHOFF: nxt_prdata = {18'h0, tsd_chan_ff, 2'h0, latched_off_ff};
      default: nxt_slverr = 1'b1;
    endcase
  end

  // Outputs, all registered; APB answers in the cycle after access starts
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drive <= '0;
      bridge_active <= '0;
      serial_status <= '0;
      irq <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      drive.enable <= nxt_active;
      drive.config_hs <= bridge_channel_config_ff & nxt_active;
      bridge_active <= nxt_active;
      serial_status <= nxt_serial;
      irq <= |(irq_stat_ff & irq_mask_ff);
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && nxt_slverr;
      prdata <= (apb_rd && !pready) ? nxt_prdata : '0;
    end
  end
endmodule
`default_nettype wire

/* design/hbfm_defs.svh */
// Constants of the half-bridge fault manager.
// Included by the package and the top module.
`ifndef HBFM_DEFS_SVH
`define HBFM_DEFS_SVH

`define HBFM_NCH 6
// APB byte addresses
`define HBFM_ADDR_CTRL 12'h000
`define HBFM_ADDR_CHCFG 12'h004
`define HBFM_ADDR_FRAME 12'h008
`define HBFM_ADDR_STATUS 12'h00C
`define HBFM_ADDR_IRQ_STAT 12'h010
`define HBFM_ADDR_IRQ_MASK 12'h014
`define HBFM_ADDR_LATCHOFF 12'h018
// Frame fields
`define HBFM_FRAME_STATUS_RESET_BIT 15
`define HBFM_FRAME_UL_SHUTDOWN_BIT 13
`define HBFM_FRAME_OV_LOCK_BIT 14
// Serial output word bit positions
`define HBFM_SO_WARN_BIT 0
`define HBFM_SO_UNDERLOAD_BIT 13
`define HBFM_SO_SUPPLY_BIT 14
`define HBFM_SO_OVERCURRENT_BIT 15
// Interrupt status bits
`define HBFM_IRQ_OVERCURRENT 0
`define HBFM_IRQ_TSD 1
`define HBFM_IRQ_UNDERLOAD 2
`define HBFM_IRQ_WARN 3
`define HBFM_IRQ_SUPPLY 4
`define HBFM_IRQ_W 5
// Over-current shutdown delay
`define HBFM_OC_DELAY_NS 10000
`define HBFM_CLK_NS 10
`define HBFM_OC_DELAY_CYC ((`HBFM_OC_DELAY_NS + `HBFM_CLK_NS - 1) / `HBFM_CLK_NS)

`endif

/* design/hbfm_pkg.sv */
// Types of the half-bridge fault manager.
// Constants live in hbfm_defs.svh.
`include "hbfm_defs.svh"

package hbfm_pkg;
  typedef struct packed {
    logic [`HBFM_NCH-1:0] oc;
    logic [`HBFM_NCH-1:0] warn;
    logic [`HBFM_NCH-1:0] tsd;
    logic [`HBFM_NCH-1:0] tsd_clear;
    logic [`HBFM_NCH-1:0] underload;
    logic supply_uv;
    logic supply_ov;
  } hbfm_sense_t;

  typedef struct packed {
    logic [`HBFM_NCH-1:0] enable;
    logic [`HBFM_NCH-1:0] config_hs;
  } hbfm_drive_t;
endpackage

/* verif/hbfm_monitor.sv */
// Checker of the fault manager, bound to hbfm_top.
// Sees only the top-level ports; single clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "hbfm_defs.svh"
module hbfm_monitor (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic chip_enable,
  input wire logic frame_valid,
  input wire logic [15:0] frame_data,
  input wire hbfm_pkg::hbfm_sense_t sense,
  input wire hbfm_pkg::hbfm_drive_t drive,
  input wire logic [`HBFM_NCH-1:0] bridge_active,
  input wire logic [15:0] serial_status
);
  import hbfm_pkg::*;
  logic [10:0] oc_cnt_ff;
  logic [2:0] clr_h_ff;
  logic ce_ff;
  logic clr;
  // Any event that may clear latched flags
  assign clr = (frame_valid && frame_data[`HBFM_FRAME_STATUS_RESET_BIT]) || (psel && penable && pwrite)
    || (chip_enable != ce_ff);
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      oc_cnt_ff <= 11'h000;
      clr_h_ff <= 3'h0;
      ce_ff <= 1'b0;
    end
    else
    begin
      oc_cnt_ff <= (|sense.oc) ? oc_cnt_ff + 11'h001 : 11'h000;
      clr_h_ff <= {clr_h_ff[1:0], clr};
      ce_ff <= chip_enable;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_warn_set: assert property ((|sense.warn) [*5] |-> serial_status[`HBFM_SO_WARN_BIT])
    else $error("thermal warning not reported");
  a_warn_clear: assert property ((!(|sense.warn)) [*5] |-> !serial_status[`HBFM_SO_WARN_BIT])
    else $error("thermal warning stuck");
  a_uv_lock: assert property (sense.supply_uv [*5] |-> bridge_active == '0)
    else $error("under-voltage did not lock out");
  a_uv_flag: assert property (sense.supply_uv [*5] |-> serial_status[`HBFM_SO_SUPPLY_BIT])
    else $error("supply fail flag missing");
  a_uv_drive: assert property (sense.supply_uv [*5] |-> drive == '0)
    else $error("drive not off in under-voltage");
  a_oc_delay: assert property ($rose(serial_status[`HBFM_SO_OVERCURRENT_BIT])
    |-> oc_cnt_ff >= 11'(`HBFM_OC_DELAY_CYC) || (|sense.tsd))
    else $error("over-current latched too early");
  a_fault_hold: assert property (serial_status[`HBFM_SO_OVERCURRENT_BIT] && !clr && clr_h_ff == 3'h0
    |=> serial_status[`HBFM_SO_OVERCURRENT_BIT])
    else $error("latched flag dropped without clear");
  a_err_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
endmodule
bind hbfm_top hbfm_monitor hbfm_monitor_inst (.ref_clk, .rst_n, .psel, .penable, .pwrite, .pready, .pslverr,
  .chip_enable, .frame_valid, .frame_data, .sense, .drive, .bridge_active, .serial_status);
`default_nettype wire

/* verif/hbfm_host_model.sv */
// Host side: issues decoded 16-bit frames.
// Driven by the bench through the send task.
`timescale 1ns/1ps
`default_nettype none
module hbfm_host_model (
  input wire logic ref_clk,
  output logic frame_valid,
  output logic [15:0] frame_data
);
  initial
  begin
    frame_valid = 1'b0;
    frame_data = 16'h0000;
  end
  // One-cycle frame, data inverted when idle
  task automatic send(input logic [15:0] f);
    @(posedge ref_clk);
    frame_valid <= 1'b1;
    frame_data <= f;
    @(posedge ref_clk);
    frame_valid <= 1'b0;
    frame_data <= ~f;
  endtask
endmodule
`default_nettype wire

/* verif/hbfm_top_tb.sv */
// Self-checking bench of hbfm_top.
// Assumes hbfm_host_model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
`include "hbfm_defs.svh"
module hbfm_top_tb;
  import hbfm_pkg::*;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;} hbfm_row_t;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, chip_enable, frame_valid, irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] frame_data, serial_status;
  logic [`HBFM_NCH-1:0] bridge_active;
  hbfm_sense_t sense;
  hbfm_drive_t drive;
  int fail_count = 0;
  int n_checks = 0;
  hbfm_row_t rows [7] = '{'{1'b0, `HBFM_ADDR_CTRL, 32'h0, 32'h0, 1'b0}, '{1'b1, `HBFM_ADDR_CHCFG, 32'h3F, 32'h0, 1'b0},
    '{1'b0, `HBFM_ADDR_CHCFG, 32'h0, 32'h3F, 1'b0}, '{1'b0, `HBFM_ADDR_STATUS, 32'h0, 32'h0, 1'b0},
    '{1'b0, 12'h01C, 32'h0, 32'h0, 1'b1}, '{1'b1, `HBFM_ADDR_IRQ_MASK, 32'h1, 32'h0, 1'b0},
    '{1'b0, `HBFM_ADDR_IRQ_MASK, 32'h0, 32'h1, 1'b0}};
  hbfm_top hbfm_top_inst (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .chip_enable, .frame_valid, .frame_data, .sense, .drive, .bridge_active, .serial_status, .irq);
  hbfm_host_model hbfm_host_model_inst (.ref_clk, .frame_valid, .frame_data);
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_checks++;
    if (g !== x)
    begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge ref_clk);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    if (pready !== 1'b1)
    begin
      fail_count++;
      summarize();
    end
  endtask
  initial
  begin
    step(100000);
    fail_count++;
    summarize();
  end
  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    chip_enable = 1'b1;
    sense = '0;
    step(4);
    chk("reset outputs", 32'h0, {9'h0, irq, serial_status, bridge_active});
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
      chk("pslverr", {31'h0, rows[i].e}, {31'h0, er});
      if (!rows[i].w && !rows[i].e)
        chk("prdata", rows[i].r, rd);
    end
    step(6);
    chk("active", 32'h3F, {26'h0, bridge_active});
    sense.warn[2] <= 1'b1;
    step(6);
    chk("warn flag", 32'h1, {31'h0, serial_status[`HBFM_SO_WARN_BIT]});
    chk("warn active", 32'h3F, {26'h0, bridge_active});
    sense.warn[2] <= 1'b0;
    step(6);
    chk("warn clear", 32'h0, {31'h0, serial_status[`HBFM_SO_WARN_BIT]});
    // Under-voltage, over-voltage without and with lockout option
    for (int o = 0; o < 3; o++)
    begin
      apb(1'b1, `HBFM_ADDR_CTRL, {30'h0, o == 2, 1'b0}, rd, er);
      sense.supply_uv <= (o == 0);
      sense.supply_ov <= (o != 0);
      step(6);
      chk("lockout", (o == 1) ? 32'h3F : 32'h0, {26'h0, bridge_active});
      chk("supply fail", 32'h1, {31'h0, serial_status[`HBFM_SO_SUPPLY_BIT]});
      sense.supply_uv <= 1'b0;
      sense.supply_ov <= 1'b0;
      step(6);
      chk("recover", 32'h3F, {26'h0, bridge_active});
    end
    sense.oc[1] <= 1'b1;
    step(900);
    chk("oc early", 32'h3F, {26'h0, bridge_active});
    step(200);
    chk("oc off", 32'h3D, {26'h0, bridge_active});
    chk("oc enable", 32'h3D, {26'h0, drive.enable});
    chk("oc flag", 32'h1, {31'h0, serial_status[`HBFM_SO_OVERCURRENT_BIT]});
    sense.oc[1] <= 1'b0;
    step(6);
    chk("oc stays off", 32'h3D, {26'h0, bridge_active});
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, `HBFM_ADDR_IRQ_MASK, 32'h0, rd, er);
    step(3);
    chk("irq masked", 32'h0, {31'h0, irq});
    hbfm_host_model_inst.send(16'h8000);
    step(6);
    chk("oc clear", 32'h0, {31'h0, serial_status[`HBFM_SO_OVERCURRENT_BIT]});
    chk("no rerun", 32'h3D, {26'h0, bridge_active});
    apb(1'b1, `HBFM_ADDR_CHCFG, 32'h3F3F, rd, er);
    apb(1'b1, `HBFM_ADDR_IRQ_MASK, 32'h1, rd, er);
    step(6);
    chk("rerun", 32'h3F, {26'h0, bridge_active});
    chk("rerun config", 32'h3F, {26'h0, drive.config_hs});
    chk("irq unmasked", 32'h1, {31'h0, irq});
    apb(1'b1, `HBFM_ADDR_IRQ_STAT, 32'h1F, rd, er);
    step(3);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // Under-load without and with shutdown control, cleared by enable toggle
    for (int s = 0; s < 2; s++)
    begin
      hbfm_host_model_inst.send(s ? 16'h2000 : 16'h0000);
      sense.underload[3] <= 1'b1;
      step(6);
      chk("underload flag", 32'h1, {31'h0, serial_status[`HBFM_SO_UNDERLOAD_BIT]});
      chk("underload active", s ? 32'h37 : 32'h3F, {26'h0, bridge_active});
      sense.underload[3] <= 1'b0;
      chip_enable <= 1'b0;
      step(2);
      chip_enable <= 1'b1;
      step(6);
      chk("underload clear", 32'h0, {31'h0, serial_status[`HBFM_SO_UNDERLOAD_BIT]});
    end
    sense.tsd[4] <= 1'b1;
    step(6);
    chk("tsd flag", 32'h1, {31'h0, serial_status[`HBFM_SO_OVERCURRENT_BIT]});
    chk("tsd off", 32'h27, {26'h0, bridge_active});
    chk("tsd config", 32'h27, {26'h0, drive.config_hs});
    sense.tsd[4] <= 1'b0;
    hbfm_host_model_inst.send(16'h8000);
    step(6);
    chk("tsd hot", 32'h1, {31'h0, serial_status[`HBFM_SO_OVERCURRENT_BIT]});
    sense.tsd_clear[4] <= 1'b1;
    step(4);
    hbfm_host_model_inst.send(16'h8000);
    step(6);
    chk("tsd clear", 32'h0, {31'h0, serial_status[`HBFM_SO_OVERCURRENT_BIT]});
    // Reset in mid-run
    rst_n <= 1'b0;
    step(2);
    chk("reset again", 32'h0, {9'h0, irq, serial_status, bridge_active});
    chk("reset drive", 32'h0, {20'h0, drive});
    rst_n <= 1'b1;
    step(6);
    chk("after reset", 32'h0, {26'h0, bridge_active});
    summarize();
  end
endmodule
`default_nettype wire
